// ### design/etcu_top.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module etcu_top #(
    parameter int TICK_CYCLES = etcu_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Camera events, one-cycle pulses
    input wire logic EXPO_BEGIN_EVENT,
    input wire logic EXPO_FINISH_EVENT,
    input wire logic SENSOR_READ_BEGIN_EVENT,
    input wire logic SENSOR_READ_FINISH_EVENT,
    input wire logic IMAGE_BEGIN_EVENT,
    input wire logic ACCEPTED_IMAGE_TRIGGER,
    input wire logic IMAGE_GROUP_FINISH_EVENT,
    // Input line levels
    input wire logic IO_INPUT_ONE,
    input wire logic IO_INPUT_TWO,
    input wire logic LINK_TRIGGER_INPUT,
    // Outputs
    output logic TMR_PULSE,
    output logic TMR_DONE_EVENT,
    output logic CNT_DONE_EVENT
);
    localparam logic [31:0] ONE = 32'h0000_0001;

    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin
            $error("etcu_top: bad TICK_CYCLES");
        end
    end

    // APB decode
    wire acc = PSEL & PENABLE;
    wire wr = acc & PWRITE;
    wire a_tctl = (PADDR == etcu_pkg::OFS_TMR_CTRL);
    wire a_tdly = (PADDR == etcu_pkg::OFS_TMR_DELAY);
    wire a_tlen = (PADDR == etcu_pkg::OFS_TMR_LENGTH);
    wire a_tcnt = (PADDR == etcu_pkg::OFS_TMR_COUNT);
    wire a_tst = (PADDR == etcu_pkg::OFS_TMR_STATE);
    wire a_cctl = (PADDR == etcu_pkg::OFS_CNT_CTRL);
    wire a_cterm = (PADDR == etcu_pkg::OFS_CNT_TERM);
    wire a_ccnt = (PADDR == etcu_pkg::OFS_CNT_COUNT);
    wire a_cmd = (PADDR == etcu_pkg::OFS_CMD);
    wire mapped = a_tctl | a_tdly | a_tlen | a_tcnt | a_tst | a_cctl |
                  a_cterm | a_ccnt | a_cmd;

    // Settings
    logic [11:0] tctl_r;
    logic [31:0] tdly_r;
    logic [31:0] tlen_r;
    logic [11:0] cctl_r;
    logic [31:0] cterm_r;
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            tctl_r <= 12'h000;
            tdly_r <= etcu_pkg::RST_ZERO;
            tlen_r <= etcu_pkg::RST_ZERO;
            cctl_r <= 12'h000;
            cterm_r <= etcu_pkg::RST_ZERO;
        end else begin
            if (wr && a_tctl) tctl_r <= PWDATA[11:0];
            if (wr && a_tdly) tdly_r <= PWDATA;
            if (wr && a_tlen) tlen_r <= PWDATA;
            if (wr && a_cctl) cctl_r <= PWDATA[11:0];
            if (wr && a_cterm) cterm_r <= PWDATA;
        end
    end
    wire tmr_enable_select = tctl_r[etcu_pkg::TC_EN_BIT];
    wire [1:0] tmr_edge_select = tctl_r[etcu_pkg::TC_EDGE_LSB +: 2];
    wire [3:0] tmr_trigger_select = tctl_r[etcu_pkg::TC_SRC_LSB +: 4];
    wire cnt_enable = cctl_r[etcu_pkg::CC_EN_BIT];
    wire [3:0] cnt_trigger_select = cctl_r[etcu_pkg::CC_START_LSB +: 4];
    wire [3:0] cnt_clear_select = cctl_r[etcu_pkg::CC_CLR_LSB +: 4];

    // Command strobes, self-clearing by nature of the write pulse
    wire tmr_clear_cmd = wr & a_cmd & PWDATA[etcu_pkg::CMD_TMR_CLR_BIT];
    wire cnt_clear_cmd = wr & a_cmd & PWDATA[etcu_pkg::CMD_CNT_CLR_BIT];
    wire tmr_load = wr & a_tcnt;

    // Microsecond tick
    logic us_tick;
    etcu_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .tick(us_tick)
    );

    // Event sources
    logic tmr_done_r;
    logic cnt_done_r;
    wire [12:0] evt = {cnt_done_r, tmr_done_r, LINK_TRIGGER_INPUT,
                       IO_INPUT_TWO, IO_INPUT_ONE, IMAGE_GROUP_FINISH_EVENT,
                       ACCEPTED_IMAGE_TRIGGER, IMAGE_BEGIN_EVENT,
                       SENSOR_READ_FINISH_EVENT, SENSOR_READ_BEGIN_EVENT,
                       EXPO_FINISH_EVENT, EXPO_BEGIN_EVENT, 1'b0};
    logic tmr_hit;
    logic cnt_clr_hit;
    // Counter clear source shares the timer's edge choice to save a register field
    etcu_evsel u_tsel (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .src(tmr_trigger_select),
        .edge_sel(tmr_edge_select),
        .evt(evt),
        .hit(tmr_hit)
    );
    etcu_evsel u_csel (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .src(cnt_clear_select),
        .edge_sel(tmr_edge_select),
        .evt(evt),
        .hit(cnt_clr_hit)
    );

    // Timer
    etcu_pkg::etcu_tmr_t tst_r, tst_nxt;
    logic [31:0] tcnt_r, tcnt_nxt;
    logic [31:0] dly_r, dly_nxt;
    wire src_off = (tmr_trigger_select == etcu_pkg::SRC_OFF);
    wire len_hit = (tcnt_r == tlen_r);
    logic tdone_nxt;
    always_comb begin
        tst_nxt = tst_r;
        tcnt_nxt = tcnt_r;
        dly_nxt = dly_r;
        tdone_nxt = 1'b0;
        case (tst_r)
            etcu_pkg::TMR_QUIET: begin
                if (tmr_enable_select) tst_nxt = etcu_pkg::TMR_ARMED;
            end
            etcu_pkg::TMR_ARMED, etcu_pkg::TMR_DONE: begin
                if (tmr_hit) begin
                    tst_nxt = etcu_pkg::TMR_DELAY;
                    dly_nxt = etcu_pkg::RST_ZERO;
                    // A rerun starts from zero; an armed timer keeps its load
                    if (tst_r == etcu_pkg::TMR_DONE) begin
                        tcnt_nxt = etcu_pkg::RST_ZERO;
                    end
                end
            end
            etcu_pkg::TMR_DELAY: begin
                if (dly_r == tdly_r) tst_nxt = etcu_pkg::TMR_RUNNING;
                else if (us_tick) dly_nxt = dly_r + ONE;
            end
            etcu_pkg::TMR_RUNNING: begin
                if (len_hit) begin
                    tst_nxt = etcu_pkg::TMR_DONE;
                    tdone_nxt = 1'b1;
                end else if (us_tick) tcnt_nxt = tcnt_r + ONE;
            end
            default: tst_nxt = etcu_pkg::TMR_QUIET;
        endcase
        if (!tmr_enable_select && tst_r != etcu_pkg::TMR_QUIET) begin
            // Leaving a run clears it; a count loaded while off is kept
            tcnt_nxt = etcu_pkg::RST_ZERO;
        end
        if (tmr_load) tcnt_nxt = PWDATA;
        if (tmr_clear_cmd && tmr_enable_select) begin
            tcnt_nxt = etcu_pkg::RST_ZERO;
            if (src_off) begin
                tst_nxt = etcu_pkg::TMR_RUNNING;
            end
        end
        if (!tmr_enable_select) tst_nxt = etcu_pkg::TMR_QUIET;
    end
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            tst_r <= etcu_pkg::TMR_QUIET;
            tcnt_r <= etcu_pkg::RST_ZERO;
            dly_r <= etcu_pkg::RST_ZERO;
            tmr_done_r <= 1'b0;
        end else begin
            tst_r <= tst_nxt;
            tcnt_r <= tcnt_nxt;
            dly_r <= dly_nxt;
            tmr_done_r <= tdone_nxt;
        end
    end
    wire [1:0] tmr_state_readback =
        (tst_r == etcu_pkg::TMR_DONE) ? etcu_pkg::RB_DONE :
        (tst_r == etcu_pkg::TMR_RUNNING) ? etcu_pkg::RB_RUNNING :
        (tst_r == etcu_pkg::TMR_QUIET) ? etcu_pkg::RB_QUIET :
        etcu_pkg::RB_ARMED;

    // Counter: counts microsecond ticks while running
    logic crun_r, crun_nxt;
    logic [31:0] ccnt_r, ccnt_nxt;
    logic cdone_nxt;
    wire self_mode = (cnt_trigger_select == etcu_pkg::SRC_CNT_DONE);
    wire cmd_mode = (cnt_trigger_select == etcu_pkg::SRC_OFF);
    wire c_term = crun_r && (ccnt_r == cterm_r);
    // Counter end as its own clear source stops it at once, not a cycle late
    wire end_clears = cmd_mode && c_term &&
                      (cnt_clear_select == etcu_pkg::SRC_CNT_DONE);
    always_comb begin
        crun_nxt = crun_r;
        ccnt_nxt = ccnt_r;
        cdone_nxt = 1'b0;
        if (crun_r && us_tick) ccnt_nxt = ccnt_r + ONE;
        if (c_term) begin
            cdone_nxt = 1'b1;
            if (self_mode) ccnt_nxt = etcu_pkg::RST_ZERO;
        end
        if (cmd_mode && cnt_clr_hit) begin
            ccnt_nxt = etcu_pkg::RST_ZERO;
            crun_nxt = 1'b0;
        end
        if (end_clears) begin
            ccnt_nxt = etcu_pkg::RST_ZERO;
            crun_nxt = 1'b0;
        end
        if (self_mode && !crun_r) crun_nxt = 1'b1;
        if (cnt_clear_cmd) begin
            ccnt_nxt = etcu_pkg::RST_ZERO;
            if (cmd_mode || self_mode) crun_nxt = 1'b1;
        end
        if (!cnt_enable || !(cmd_mode || self_mode)) begin
            crun_nxt = 1'b0;
        end
    end
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            crun_r <= 1'b0;
            ccnt_r <= etcu_pkg::RST_ZERO;
            cnt_done_r <= 1'b0;
        end else begin
            crun_r <= crun_nxt;
            ccnt_r <= ccnt_nxt;
            cnt_done_r <= cdone_nxt;
        end
    end

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        if (a_tctl) begin
            rdata = {20'h00000, tctl_r};
        end else if (a_tdly) begin
            rdata = tdly_r;
        end else if (a_tlen) begin
            rdata = tlen_r;
        end else if (a_tcnt) begin
            rdata = tcnt_r;
        end else if (a_tst) begin
            rdata = {30'h0, tmr_state_readback};
        end else if (a_cctl) begin
            rdata = {20'h00000, cctl_r};
        end else if (a_cterm) begin
            rdata = cterm_r;
        end else if (a_ccnt) begin
            rdata = ccnt_r;
        end else begin
            rdata = 32'h0000_0000;
        end
    end
    // Captured in the setup cycle, so data stands through the access phase
    logic [31:0] prdata_r;
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) prdata_r <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE) prdata_r <= rdata;
    end
    assign PRDATA = prdata_r;
    // Every register answers at once: no wait states
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~mapped;
    assign TMR_PULSE = (tst_r == etcu_pkg::TMR_RUNNING);
    assign TMR_DONE_EVENT = tmr_done_r;
    assign CNT_DONE_EVENT = cnt_done_r;
endmodule // etcu_top

// ### inc/etcu_pkg.sv
package etcu_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_TMR_CTRL = 8'h00;
    localparam logic [7:0] OFS_TMR_DELAY = 8'h04;
    localparam logic [7:0] OFS_TMR_LENGTH = 8'h08;
    localparam logic [7:0] OFS_TMR_COUNT = 8'h0C;
    localparam logic [7:0] OFS_TMR_STATE = 8'h10;
    localparam logic [7:0] OFS_CNT_CTRL = 8'h14;
    localparam logic [7:0] OFS_CNT_TERM = 8'h18;
    localparam logic [7:0] OFS_CNT_COUNT = 8'h1C;
    localparam logic [7:0] OFS_CMD = 8'h20;
    // Timer control fields
    localparam int TC_EN_BIT = 0;
    localparam int TC_EDGE_LSB = 4;
    localparam int TC_SRC_LSB = 8;
    // Counter control fields
    localparam int CC_EN_BIT = 0;
    localparam int CC_START_LSB = 4;
    localparam int CC_CLR_LSB = 8;
    // Command bits
    localparam int CMD_TMR_CLR_BIT = 0;
    localparam int CMD_CNT_CLR_BIT = 1;
    // Timing
    localparam int CLOCK_MHZ = 125;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = TICK_US * CLOCK_MHZ;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Trigger sources
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_EXPO_BEGIN = 4'h1;
    localparam logic [3:0] SRC_EXPO_FINISH = 4'h2;
    localparam logic [3:0] SRC_READ_BEGIN = 4'h3;
    localparam logic [3:0] SRC_READ_FINISH = 4'h4;
    localparam logic [3:0] SRC_IMAGE_BEGIN = 4'h5;
    localparam logic [3:0] SRC_ACC_TRIG = 4'h6;
    localparam logic [3:0] SRC_GROUP_FINISH = 4'h7;
    localparam logic [3:0] SRC_IO_ONE = 4'h8;
    localparam logic [3:0] SRC_IO_TWO = 4'h9;
    localparam logic [3:0] SRC_LINK = 4'hA;
    localparam logic [3:0] SRC_TMR_DONE = 4'hB;
    localparam logic [3:0] SRC_CNT_DONE = 4'hC;
    // Edge choices
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_ANY = 2'h2;
    // Timer state readback codes
    localparam logic [1:0] RB_QUIET = 2'h0;
    localparam logic [1:0] RB_ARMED = 2'h1;
    localparam logic [1:0] RB_RUNNING = 2'h2;
    localparam logic [1:0] RB_DONE = 2'h3;
    typedef enum logic [4:0] {
        TMR_QUIET = 5'b00001,
        TMR_ARMED = 5'b00010,
        TMR_DELAY = 5'b00100,
        TMR_RUNNING = 5'b01000,
        TMR_DONE = 5'b10000
    } etcu_tmr_t;
endpackage

// ### design/etcu_tick.sv
`timescale 1ns/1ps
module etcu_tick #(
    parameter int CYCLES = etcu_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Tick out
    output logic tick
);
    initial begin
        if (CYCLES < 2 || CYCLES > 65535) $error("etcu_tick: bad CYCLES");
    end
    localparam logic [15:0] LAST = 16'(CYCLES - 1);
    logic [15:0] pre_r;
    wire wrap = (pre_r == LAST);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) pre_r <= 16'h0000;
        else pre_r <= wrap ? 16'h0000 : pre_r + 16'h0001;
    end
    assign tick = wrap;
endmodule // etcu_tick

// ### design/etcu_evsel.sv
`timescale 1ns/1ps
module etcu_evsel (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Selection
    input wire logic [3:0] src,
    input wire logic [1:0] edge_sel,
    // Sources
    input wire logic [12:0] evt,
    // Selected edge or event pulse
    output logic hit
);
    logic [2:0] lvl_r;
    wire [2:0] lvl = evt[10:8];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) lvl_r <= 3'h0;
        else lvl_r <= lvl;
    end
    logic [2:0] edg;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_edge
            wire rise = lvl[g] & ~lvl_r[g];
            wire fall = ~lvl[g] & lvl_r[g];
            assign edg[g] = (edge_sel == etcu_pkg::EDGE_RISE) ? rise :
                            (edge_sel == etcu_pkg::EDGE_FALL) ? fall :
                            (edge_sel == etcu_pkg::EDGE_ANY) ? (rise | fall) :
                            1'b0;
        end
    endgenerate
    wire is_line = (src >= etcu_pkg::SRC_IO_ONE) && (src <= etcu_pkg::SRC_LINK);
    wire [3:0] li = src - etcu_pkg::SRC_IO_ONE;
    assign hit = (src == etcu_pkg::SRC_OFF) ? 1'b0 :
                 is_line ? edg[li[1:0]] :
                 (src <= etcu_pkg::SRC_CNT_DONE) ? evt[src] :
                 1'b0;
endmodule // etcu_evsel

// ### test/etcu_top_monitor.sv
`timescale 1ns/1ps
module etcu_top_monitor (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Timer and counter outputs
    input wire logic TMR_PULSE,
    input wire logic TMR_DONE_EVENT,
    input wire logic CNT_DONE_EVENT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    wire logic acc = PSEL && PENABLE;
    wire logic bad_adr = PADDR[1:0] != 2'h0 || PADDR > 8'h20;
    wire logic ten_wr = acc && PWRITE && PADDR == etcu_pkg::OFS_TMR_CTRL;
    logic ten_r;
    // Bus-side copy of the timer enable, so no internal probe is needed
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N)
            ten_r <= 1'b0;
        else if (ten_wr)
            ten_r <= PWDATA[etcu_pkg::TC_EN_BIT];
    end
    property p_ready; PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    property p_err_map; acc && bad_adr |-> PSLVERR; endproperty
    a_err_map: assert property (p_err_map) else $error("no slave error");
    property p_err_idle; !acc || !bad_adr |-> !PSLVERR; endproperty
    a_err_idle: assert property (p_err_idle) else $error("stray error");
    property p_err_rd; acc && !PWRITE && bad_adr |-> PRDATA == 32'h0;
    endproperty
    a_err_rd: assert property (p_err_rd) else $error("unmapped data");
    property p_tdone_one; TMR_DONE_EVENT |=> !TMR_DONE_EVENT; endproperty
    a_tdone_one: assert property (p_tdone_one) else $error("timer done long");
    property p_cdone_one; CNT_DONE_EVENT |=> !CNT_DONE_EVENT; endproperty
    a_cdone_one: assert property (p_cdone_one) else $error("cnt done long");
    property p_tdone_run; TMR_DONE_EVENT |-> !TMR_PULSE &&
        ($past(TMR_PULSE) || $past(TMR_PULSE, 2)); endproperty
    a_tdone_run: assert property (p_tdone_run) else $error("done w/o pulse");
    property p_off; !ten_r |=> !TMR_PULSE; endproperty
    a_off: assert property (p_off) else $error("pulse while off");
endmodule // etcu_top_monitor
bind etcu_top etcu_top_monitor u_mon (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TMR_PULSE(TMR_PULSE), .TMR_DONE_EVENT(TMR_DONE_EVENT),
    .CNT_DONE_EVENT(CNT_DONE_EVENT));

// ### test/etcu_partner.sv
`timescale 1ns/1ps
module etcu_partner (
    // Clock
    input wire logic clk,
    // Camera events and line levels
    output logic [6:0] ev,
    output logic [2:0] ln
);
    initial begin
        ev = 7'h00;
        ln = 3'h0;
    end
    // Acquisition events are one clock wide, never held
    task automatic fire(input int i);
        @(posedge clk);
        ev <= 7'h01 << i;
        @(posedge clk);
        ev <= 7'h00;
    endtask
    task automatic level(input int i, input logic v);
        @(posedge clk);
        ln[i] <= v;
    endtask
endmodule // etcu_partner

// ### test/etcu_top_test.sv
`timescale 1ns/1ps
module etcu_top_test;
    logic clock, arst_n, psel, penable, pwrite, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, tpulse, tdone, cdone;
    logic [6:0] ev;
    logic [2:0] ln;
    int bad_count, samples_checked, cycles, n, w, e, s;
    etcu_top u_dut (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXPO_BEGIN_EVENT(ev[0]),
        .EXPO_FINISH_EVENT(ev[1]), .SENSOR_READ_BEGIN_EVENT(ev[2]),
        .SENSOR_READ_FINISH_EVENT(ev[3]), .IMAGE_BEGIN_EVENT(ev[4]),
        .ACCEPTED_IMAGE_TRIGGER(ev[5]), .IMAGE_GROUP_FINISH_EVENT(ev[6]),
        .IO_INPUT_ONE(ln[0]), .IO_INPUT_TWO(ln[1]),
        .LINK_TRIGGER_INPUT(ln[2]), .TMR_PULSE(tpulse),
        .TMR_DONE_EVENT(tdone), .CNT_DONE_EVENT(cdone));
    etcu_partner u_far (.clk(clock), .ev(ev), .ln(ln));
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string t, logic [31:0] lo, hi, g);
        samples_checked++;
        if ($isunknown(g) || g < lo || g > hi) begin
            bad_count++;
            $display("Error %s expected %0h..%0h seen %0h", t, lo, hi, g);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(logic [7:0] a, logic [31:0] lo, hi);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), lo, hi, q);
    endtask
    // Counts cycles to the done event, and pulse-high cycles meanwhile
    task automatic wait_ev(logic c);
        n = 0;
        w = 0;
        do begin
            @(posedge clock);
            n++;
            w += tpulse;
        end while ((c ? cdone : tdone) !== 1'b1 && n < 2000);
    endtask
    initial begin
        {clock, arst_n, psel, penable, pwrite} = 5'h00;
        {paddr, pwdata, bad_count, samples_checked, cycles} = 0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        rchk(etcu_pkg::OFS_TMR_STATE, 0, 0);
        rchk(8'h24, 0, 0);
        chk("slave error", 1, 1, perr);
        wr(etcu_pkg::OFS_TMR_DELAY, 32'h2);
        wr(etcu_pkg::OFS_TMR_LENGTH, 32'h2);
        for (int i = 0; i < 7; i++) begin
            wr(etcu_pkg::OFS_TMR_CTRL, 1 | (i + 1) << etcu_pkg::TC_SRC_LSB);
            rchk(etcu_pkg::OFS_TMR_STATE, 1, 1);
            u_far.fire(i);
            wait_ev(1'b0);
            chk("start to end", 370, 505, n);
            chk("pulse width", 240, 255, w);
            rchk(etcu_pkg::OFS_TMR_STATE, 3, 3);
            wr(etcu_pkg::OFS_TMR_CTRL, 32'h0);
            rchk(etcu_pkg::OFS_TMR_STATE, 0, 0);
        end
        $display("test internal sources done");
        wr(etcu_pkg::OFS_TMR_DELAY, 32'h0);
        wr(etcu_pkg::OFS_TMR_LENGTH, 32'h1);
        for (int k = 0; k < 9; k++) begin
            e = k % 3;
            s = k / 3;
            u_far.level(s, e == 0);
            wr(etcu_pkg::OFS_TMR_CTRL, 1 | e << etcu_pkg::TC_EDGE_LSB |
                (8 + s) << etcu_pkg::TC_SRC_LSB);
            if (e != 2) begin
                u_far.level(s, e == 1);
                rchk(etcu_pkg::OFS_TMR_STATE, 1, 1);
            end
            u_far.level(s, e != 1);
            wait_ev(1'b0);
            chk("line start", 1, 140, n);
            wr(etcu_pkg::OFS_TMR_CTRL, 32'h0);
        end
        $display("test lines and edges done");
        wr(etcu_pkg::OFS_TMR_CTRL, 32'h1);
        wr(etcu_pkg::OFS_TMR_COUNT, 32'h3);
        rchk(etcu_pkg::OFS_TMR_COUNT, 3, 3);
        rchk(etcu_pkg::OFS_TMR_STATE, 1, 1);
        wr(etcu_pkg::OFS_CMD, 32'h1 << etcu_pkg::CMD_TMR_CLR_BIT);
        rchk(etcu_pkg::OFS_TMR_STATE, 2, 2);
        rchk(etcu_pkg::OFS_TMR_COUNT, 0, 1);
        wait_ev(1'b0);
        chk("clear run", 1, 140, n);
        wr(etcu_pkg::OFS_TMR_CTRL, 1 << etcu_pkg::TC_SRC_LSB);
        u_far.fire(0);
        wr(etcu_pkg::OFS_CMD, 32'h1 << etcu_pkg::CMD_TMR_CLR_BIT);
        rchk(etcu_pkg::OFS_TMR_STATE, 0, 0);
        $display("test command start done");
        wr(etcu_pkg::OFS_CNT_TERM, 32'h2);
        wr(etcu_pkg::OFS_TMR_CTRL, 1 | 12 << etcu_pkg::TC_SRC_LSB);
        wr(etcu_pkg::OFS_CNT_CTRL, 32'h0CC1);
        wait_ev(1'b1);
        chk("first end", 1, 400, n);
        wait_ev(1'b1);
        chk("end period", 245, 380, n);
        wait_ev(1'b0);
        chk("timer on count end", 1, 140, n);
        wr(etcu_pkg::OFS_CMD, 32'h1 << etcu_pkg::CMD_CNT_CLR_BIT);
        rchk(etcu_pkg::OFS_CNT_COUNT, 0, 1);
        wait_ev(1'b1);
        chk("end after clear", 120, 380, n);
        wr(etcu_pkg::OFS_CNT_CTRL, 32'h0);
        wr(etcu_pkg::OFS_TMR_CTRL, 32'h0);
        $display("test self restart done");
        wr(etcu_pkg::OFS_CNT_TERM, 32'h3);
        for (int k = 0; k < 2; k++) begin
            wr(etcu_pkg::OFS_CNT_CTRL, k ? 32'h0C01 : 32'h0101);
            repeat (300) @(posedge clock);
            rchk(etcu_pkg::OFS_CNT_COUNT, 0, 0);
            for (int j = 0; j < 2; j++) begin
                wr(etcu_pkg::OFS_CMD, 32'h1 << etcu_pkg::CMD_CNT_CLR_BIT);
                repeat (130) @(posedge clock);
                rchk(etcu_pkg::OFS_CNT_COUNT, 1, 2);
                if (k)
                    wait_ev(1'b1);
                else
                    u_far.fire(0);
                repeat (300) @(posedge clock);
                rchk(etcu_pkg::OFS_CNT_COUNT, 0, 0);
            end
            wr(etcu_pkg::OFS_CNT_CTRL, 32'h0);
        end
        $display("test counter stop done");
        conclude();
    end
endmodule // etcu_top_test
